//--- shared/ivp_pkg.sv
// Constants and types for the vector select and pin interrupt block.
// Assumes an 8-bit register port on the core clock and fuse levels held static.
// How it works
// RULE1 - Select bit picks flash or boot vector base
// RULE2 - Boot base follows boot size fuses
// RULE3 - Software unlocks, then writes select within four
// RULE4 - Unlock self-clears after four cycles or select
// RULE5 - Interrupts blocked during the change sequence
// RULE6 - Blocking never touches the global enable flag
// RULE7 - Boot vectors plus app lock: mute app code
// RULE8 - App vectors plus boot lock: mute boot code
// RULE9 - Pins interrupt even when driven as outputs
// RULE10 - Group requests on any enabled input toggle
// RULE11 - Per-group masks select contributing inputs
// RULE12 - Pin change wakes without the I/O clock
// RULE13 - Dedicated pins: falling, rising or low level
// RULE14 - Low level keeps requesting while pin low
// RULE15 - Edge detection needs the running I/O clock
// RULE16 - Low level detection works without I/O clock
// RULE17 - I/O clock stops in all sleep but idle
// RULE18 - Level wake gives interrupt only if held
// RULE19 - Sense codes: low, any, falling, rising
// RULE20 - Pins sampled before edge detection
// RULE21 - Edge flag: cleared by entry or write one
// RULE22 - Toggle seen as input differing from stored
package ivp_pkg;
	// Register addresses on the core register port
	localparam logic [7:0] ADR_MCU_CONTROL = 8'h35;
	localparam logic [7:0] ADR_EXT_SENSE = 8'h69;
	localparam logic [7:0] ADR_EXT_MASK = 8'h3d;
	localparam logic [7:0] ADR_EXT_FLAG = 8'h3c;
	localparam logic [7:0] ADR_PC_CTRL = 8'h68;
	localparam logic [7:0] ADR_PC_MASK_LOW = 8'h6b;
	localparam logic [7:0] ADR_PC_MASK_MID = 8'h6c;
	localparam logic [7:0] ADR_PC_MASK_HIGH = 8'h6d;
	// Field positions and reset values
	localparam int BIT_VEC_UNLOCK = 0;
	localparam int BIT_VEC_SELECT = 1;
	localparam int BIT_PULLUP_DIS = 4;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] PC_MID_USED = 8'h7f;
	// Unlock window length in core cycles
	localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
	// Relocated vector base per boot size fuse code (word addresses)
	localparam logic [12:0] BOOT_BASE_TBL [4] = '{13'h1c00, 13'h1e00, 13'h1f00, 13'h1f80};
	localparam logic [12:0] FLASH_BASE = 13'h0000;
	// Request lines
	localparam int IRQ_EXT_A = 0;
	localparam int IRQ_PC_LOW = 2;
	localparam int IRQ_N = 5;
	typedef enum logic [1:0] {
		SNS_LOW = 2'h0,
		SNS_ANY = 2'h1,
		SNS_FALL = 2'h2,
		SNS_RISE = 2'h3
	} ivp_sense_t;
	typedef enum logic [2:0] {
		VS_IDLE = 3'b001,
		VS_OPEN = 3'b010,
		VS_HOLD = 3'b100
	} ivp_vs_state_t;
endpackage : ivp_pkg

//--- shared/ivp_vec_if.sv
// Link between register decode and the vector select sequencer.
// Assumes both ends run on the core clock.
`timescale 1ns/1ns
interface ivp_vec_if;
	logic wr_unlock;
	logic wr_sel;
	logic wdata_sel;
	logic instr_done;
	logic sel;
	logic unlock;
	logic block;
	modport ctl (output wr_unlock, output wr_sel, output wdata_sel, output instr_done,
		input sel, input unlock, input block);
	modport seq (input wr_unlock, input wr_sel, input wdata_sel, input instr_done,
		output sel, output unlock, output block);
endinterface : ivp_vec_if

//--- hdl/ivp_vecsel.sv
// Vector base select with its timed unlock sequence.
// Assumes write strobes are one-cycle pulses decoded by the top.
`timescale 1ns/1ns
module ivp_vecsel import ivp_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	ivp_vec_if.seq v
);
	typedef struct packed {
		ivp_vs_state_t st;
		logic [2:0] cnt;
		logic sel;
	} ivp_vs_st_t;
	ivp_vs_st_t s_q, s_d;

	// Sequencer; a rewrite of the unlock bit restarts the window
	always_comb begin
		s_d = s_q;
		unique case (s_q.st)
			VS_IDLE: if (v.wr_unlock) begin
				s_d.st = VS_OPEN;
				s_d.cnt = 3'h1;
			end
			VS_OPEN: if (v.wr_sel) begin
				s_d.sel = v.wdata_sel; // [RULE3] [RULE4]
				s_d.st = VS_HOLD;
			end else if (v.wr_unlock) begin
				s_d.cnt = 3'h1;
			end else if (s_q.cnt == UNLOCK_CYCLES) begin
				s_d.st = VS_IDLE; // [RULE4]
			end else begin
				s_d.cnt = s_q.cnt + 3'h1;
			end
			// A fresh unlock write reopens the window rather than being lost
			VS_HOLD: if (v.wr_unlock) begin
				s_d.st = VS_OPEN;
				s_d.cnt = 3'h1;
			end else if (v.instr_done) begin
				s_d.st = VS_IDLE; // [RULE5]
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{st: VS_IDLE, cnt: 3'h0, sel: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign v.sel = s_q.sel;
	assign v.unlock = (s_q.st == VS_OPEN);
	// Block starts in the very write cycle, before the state settles
	assign v.block = v.wr_unlock || (s_q.st != VS_IDLE); // [RULE5]

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_UNLOCK_TIMEOUT: assert property (v.wr_unlock ##1 (!v.wr_sel && !v.wr_unlock)[*4] |=> !v.unlock) // [RULE4]
		else $error("unlock bit outlived its window");
	AST_UNLOCK_LIVES: assert property (v.wr_unlock ##1 (!v.wr_sel && !v.wr_unlock)[*3] |-> v.unlock) // [RULE4]
		else $error("unlock bit cleared too early");
	AST_SEL_TAKEN: assert property (v.unlock && v.wr_sel |=> !v.unlock && v.sel == $past(v.wdata_sel)) // [RULE3]
		else $error("select write inside window not taken");
	AST_SEL_LOCKED: assert property (!v.unlock |=> $stable(v.sel)) // [RULE3]
		else $error("select changed without unlock");
	AST_BLOCK_SEQ: assert property (v.wr_unlock ##1 (!v.wr_sel)[*3] |-> v.block) // [RULE5]
		else $error("interrupts not blocked during unlock window");
	COV_MOVE: cover property (v.wr_unlock ##[1:4] v.wr_sel ##[1:8] !v.block);
	COV_TIMEOUT: cover property (v.wr_unlock ##1 !v.wr_sel [*5]);
endmodule : ivp_vecsel

//--- hdl/ivp_extirq.sv
// Sense logic for one dedicated external interrupt pin.
// Assumes the pin is synchronous to the core clock.
`timescale 1ns/1ns
module ivp_extirq import ivp_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pin,
	input wire ivp_sense_t sense,
	input wire logic io_run,
	input wire logic clr,
	output logic flag
);
	typedef struct packed {
		logic smp;
		logic prev;
		logic flag;
	} ivp_ex_st_t;
	ivp_ex_st_t s_q, s_d;
	logic hit;

	// Edge seen on the sampled copy only, so glitches under a cycle may be lost
	always_comb begin
		s_d = s_q;
		hit = 1'b0;
		if (io_run) begin
			s_d.smp = pin; // [RULE20]
			s_d.prev = s_q.smp;
			unique case (sense)
				SNS_LOW: hit = 1'b0;
				SNS_ANY: hit = s_q.smp ^ s_q.prev; // [RULE19]
				SNS_FALL: hit = s_q.prev && !s_q.smp; // [RULE13]
				SNS_RISE: hit = !s_q.prev && s_q.smp; // [RULE13]
			endcase
		end
		// Set beats clear; level mode holds the flag at zero
		if (sense == SNS_LOW) begin
			s_d.flag = 1'b0; // [RULE21]
		end else if (hit) begin
			s_d.flag = 1'b1; // [RULE15]
		end else if (clr) begin
			s_d.flag = 1'b0; // [RULE21]
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{smp: 1'b1, prev: 1'b1, flag: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign flag = s_q.flag;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_FALL_SETS: assert property (io_run && sense == SNS_FALL && s_q.prev && !s_q.smp |=> flag) // [RULE13]
		else $error("falling edge missed");
	AST_LEVEL_NOFLAG: assert property (sense == SNS_LOW |=> !flag) // [RULE21]
		else $error("flag set in level mode");
	AST_NOCLK_NOEDGE: assert property (!io_run && !flag |=> !flag) // [RULE15]
		else $error("edge flag set with I/O clock stopped");
	AST_ACK_CLEARS: assert property (flag && clr && io_run && sense == SNS_RISE && !(!s_q.prev && s_q.smp)
		|=> !flag) // [RULE21]
		else $error("flag not cleared by acknowledge");
	COV_ANY: cover property (sense == SNS_ANY ##1 $rose(flag));
endmodule : ivp_extirq

//--- hdl/ivp_top.sv
// Vector base select and external/pin-change interrupt sources.
// Assumes a one-cycle register write strobe and registered read data,
// fuses and lock bits static, and pins synchronous to the core clock.
`timescale 1ns/1ns
module ivp_top import ivp_pkg::*; (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic [7:0] IO_ADDR,
	input wire logic [7:0] IO_WDATA,
	input wire logic IO_WE,
	input wire logic IO_RE,
	output logic [7:0] IO_RDATA,
	input wire logic [1:0] EXT_PIN,
	input wire logic [23:0] PC_PIN,
	input wire logic [4:0] IRQ_ACK,
	input wire logic INSTR_DONE,
	input wire logic GLOBAL_IE,
	input wire logic SLEEP_ACTIVE,
	input wire logic SLEEP_IDLE,
	input wire logic EXEC_IN_BOOT,
	input wire logic APP_LOCK_PROG,
	input wire logic BOOT_LOCK_PROG,
	input wire logic [1:0] BOOT_SIZE_FUSES,
	output logic [12:0] VEC_BASE,
	output logic [4:0] IRQ_REQ,
	output logic IRQ_ALLOW,
	output logic WAKE,
	output logic IO_CLK_RUN,
	output logic PULLUP_DISABLE
);
	typedef struct packed {
		logic pullup_disable;
		logic [3:0] sense;
		logic [1:0] ext_en;
		logic [2:0] pc_en;
		logic [23:0] pc_mask;
		logic [23:0] pc_prev;
		logic [2:0] pc_flag;
		logic [7:0] rdata;
		logic [12:0] vbase;
	} ivp_top_st_t;
	ivp_top_st_t s_q, s_d;

	ivp_vec_if vif ();
	logic wr_mcu;
	logic [1:0] ext_flag;
	logic [1:0] ext_clr;
	logic [23:0] pc_diff;
	logic [2:0] pc_hit;
	logic [1:0] lvl_low;
	logic lock_mute;
	logic io_run;

	// I/O clock halts in every sleep mode but idle
	assign io_run = !SLEEP_ACTIVE || SLEEP_IDLE; // [RULE17]
	assign IO_CLK_RUN = io_run;

	// Control register write decode feeding the sequencer
	assign wr_mcu = IO_WE && (IO_ADDR == ADR_MCU_CONTROL);
	assign vif.wr_unlock = wr_mcu && IO_WDATA[BIT_VEC_UNLOCK]; // [RULE3]
	assign vif.wr_sel = wr_mcu && !IO_WDATA[BIT_VEC_UNLOCK] && vif.unlock; // [RULE3]
	assign vif.wdata_sel = IO_WDATA[BIT_VEC_SELECT];
	assign vif.instr_done = INSTR_DONE;

	ivp_vecsel u_vecsel (
		.clk(MCLK),
		.rst_n(RST_N),
		.v(vif.seq)
	);

	// Edge flags clear on vector entry or on a write of one
	assign ext_clr = IRQ_ACK[1:0] | ((IO_WE && IO_ADDR == ADR_EXT_FLAG) ? IO_WDATA[1:0] : 2'h0); // [RULE21]

	// One sense block per dedicated pin; pin input taken whatever its direction
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ext
			ivp_extirq u_ext (
				.clk(MCLK),
				.rst_n(RST_N),
				.pin(EXT_PIN[gi]), // [RULE9]
				.sense(ivp_sense_t'(s_q.sense[2*gi +: 2])),
				.io_run(io_run),
				.clr(ext_clr[gi]),
				.flag(ext_flag[gi])
			);
			assign lvl_low[gi] = s_q.ext_en[gi] && (s_q.sense[2*gi +: 2] == SNS_LOW) && !EXT_PIN[gi]; // [RULE16]
		end
	endgenerate

	// Toggle is a masked difference from the stored copy; no clock needed
	assign pc_diff = (PC_PIN ^ s_q.pc_prev) & s_q.pc_mask; // [RULE22] [RULE11]
	generate
		for (gi = 0; gi < 3; gi++) begin : g_pc
			assign pc_hit[gi] = |pc_diff[8*gi +: 8]; // [RULE10]
		end
	endgenerate

	// Async wake path: enabled pin change or held low level
	assign WAKE = |(pc_hit & s_q.pc_en) || |lvl_low; // [RULE12] [RULE16]

	// Lock bits mute interrupts in the section the vectors do not sit in
	assign lock_mute = (vif.sel && APP_LOCK_PROG && !EXEC_IN_BOOT) // [RULE7]
		|| (!vif.sel && BOOT_LOCK_PROG && EXEC_IN_BOOT); // [RULE8]
	// Global enable is only read here, never written back
	assign IRQ_ALLOW = GLOBAL_IE && !vif.block && !lock_mute; // [RULE5] [RULE6]

	// Level requests wait for the core to run so a lost level gives no vector
	always_comb begin
		IRQ_REQ = '0;
		for (int i = 0; i < 2; i++) begin
			IRQ_REQ[IRQ_EXT_A + i] = s_q.ext_en[i] && ((lvl_low[i] && !SLEEP_ACTIVE) || ext_flag[i]); // [RULE14] [RULE18]
		end
		IRQ_REQ[IRQ_PC_LOW +: 3] = s_q.pc_flag & s_q.pc_en;
	end

	// Register file, flags and read mux
	always_comb begin
		s_d = s_q;
		s_d.rdata = s_q.rdata;
		if (io_run) begin
			s_d.pc_prev = PC_PIN; // [RULE22]
		end
		// Set wins over acknowledge in the same cycle
		for (int g = 0; g < 3; g++) begin
			if (io_run && pc_hit[g]) begin
				s_d.pc_flag[g] = 1'b1; // [RULE10]
			end else if (IRQ_ACK[IRQ_PC_LOW + g]) begin
				s_d.pc_flag[g] = 1'b0;
			end
		end
		if (IO_WE) begin
			unique case (IO_ADDR)
				ADR_MCU_CONTROL: s_d.pullup_disable = IO_WDATA[BIT_PULLUP_DIS];
				ADR_EXT_SENSE: s_d.sense = IO_WDATA[3:0]; // [RULE19]
				ADR_EXT_MASK: s_d.ext_en = IO_WDATA[1:0];
				ADR_PC_CTRL: s_d.pc_en = IO_WDATA[2:0];
				ADR_PC_MASK_LOW: s_d.pc_mask[7:0] = IO_WDATA; // [RULE11]
				ADR_PC_MASK_MID: s_d.pc_mask[15:8] = IO_WDATA & PC_MID_USED; // [RULE11]
				ADR_PC_MASK_HIGH: s_d.pc_mask[23:16] = IO_WDATA; // [RULE11]
				default: s_d.pullup_disable = s_q.pullup_disable;
			endcase
		end
		// Reserved bits and unmapped addresses read zero
		if (IO_RE) begin
			unique case (IO_ADDR)
				ADR_MCU_CONTROL: s_d.rdata = {3'h0, s_q.pullup_disable, 2'h0, vif.sel, vif.unlock};
				ADR_EXT_SENSE: s_d.rdata = {4'h0, s_q.sense};
				ADR_EXT_MASK: s_d.rdata = {6'h0, s_q.ext_en};
				ADR_EXT_FLAG: s_d.rdata = {6'h0, ext_flag};
				ADR_PC_CTRL: s_d.rdata = {5'h0, s_q.pc_en};
				ADR_PC_MASK_LOW: s_d.rdata = s_q.pc_mask[7:0];
				ADR_PC_MASK_MID: s_d.rdata = s_q.pc_mask[15:8];
				ADR_PC_MASK_HIGH: s_d.rdata = s_q.pc_mask[23:16];
				default: s_d.rdata = 8'h00;
			endcase
		end
		// Base follows select and fuses; registered so the output is clean
		s_d.vbase = vif.sel ? BOOT_BASE_TBL[BOOT_SIZE_FUSES] : FLASH_BASE; // [RULE1] [RULE2]
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign IO_RDATA = s_q.rdata;
	assign VEC_BASE = s_q.vbase;
	assign PULLUP_DISABLE = s_q.pullup_disable;

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	AST_VEC_BASE: assert property (##1 VEC_BASE == ($past(vif.sel) ? BOOT_BASE_TBL[$past(BOOT_SIZE_FUSES)]
		: FLASH_BASE)) // [RULE1]
		else $error("vector base does not follow select");
	AST_BASE_2K: assert property (vif.sel && BOOT_SIZE_FUSES == 2'h0 |=> VEC_BASE == 13'h1c00) // [RULE2]
		else $error("boot base wrong for largest boot section");
	AST_LOCK_APP: assert property (vif.sel && APP_LOCK_PROG && !EXEC_IN_BOOT |-> !IRQ_ALLOW) // [RULE7]
		else $error("interrupt allowed in locked application code");
	AST_LOCK_BOOT: assert property (!vif.sel && BOOT_LOCK_PROG && EXEC_IN_BOOT |-> !IRQ_ALLOW) // [RULE8]
		else $error("interrupt allowed in locked boot code");
	// Outside the sequence and the lock mutes, the allow line is the untouched enable
	AST_GIE_KEPT: assert property (!vif.block && !lock_mute |-> IRQ_ALLOW == GLOBAL_IE) // [RULE6]
		else $error("allow line disagrees with global enable");
	AST_PC_FIRES: assert property (io_run && pc_hit[0] |=> s_q.pc_flag[0]) // [RULE10]
		else $error("pin change toggle lost");
	AST_MASK_GATES: assert property (s_q.pc_mask[23:16] == 8'h00 |-> !pc_hit[2]) // [RULE11]
		else $error("masked input contributed");
	AST_PC_WAKE: assert property (SLEEP_ACTIVE && pc_hit[1] && s_q.pc_en[1] |-> WAKE) // [RULE12]
		else $error("pin change did not wake");
	AST_LEVEL_HOLD: assert property ((lvl_low[0] && !SLEEP_ACTIVE)[*3] |-> IRQ_REQ[IRQ_EXT_A]) // [RULE14]
		else $error("level request dropped while pin low");
	AST_LEVEL_WAKE: assert property (SLEEP_ACTIVE && lvl_low[0] // [RULE16]
		|-> WAKE && (!IRQ_REQ[IRQ_EXT_A] || ext_flag[0]))
		else $error("level did not wake");
	AST_SLEEP_CLK: assert property (SLEEP_ACTIVE && !SLEEP_IDLE |-> !IO_CLK_RUN) // [RULE17]
		else $error("I/O clock running in deep sleep");
	// Change sequence mutes the allow line; a clear select pins the base to flash
	AST_BLOCK_MUTE: assert property (vif.block |-> !IRQ_ALLOW) // [RULE5]
		else $error("interrupt allowed during vector change");
	AST_BASE_FLASH: assert property (!vif.sel |=> VEC_BASE == FLASH_BASE) // [RULE1]
		else $error("vector base left flash with select clear");
	// Edge and pin-change requests follow their flags and enables
	AST_EDGE_REQ: assert property (s_q.ext_en[0] && ext_flag[0] |-> IRQ_REQ[IRQ_EXT_A]) // [RULE21]
		else $error("edge flag raised no request");
	AST_PC_REQ: assert property (s_q.pc_flag[1] && s_q.pc_en[1] |-> IRQ_REQ[IRQ_PC_LOW + 1]) // [RULE10]
		else $error("mid group flag raised no request");
	// The mid group has only seven inputs; its top mask bit must never stick
	AST_MID_GAP: assert property (!s_q.pc_mask[15]) // [RULE10]
		else $error("unused mid group input enabled");
	AST_COPY_TRACKS: assert property (io_run |=> s_q.pc_prev == $past(PC_PIN)) // [RULE22]
		else $error("stored pin copy not refreshed");
	AST_MASK_WRITE: assert property (IO_WE && IO_ADDR == ADR_PC_MASK_LOW // [RULE11]
		|=> s_q.pc_mask[7:0] == $past(IO_WDATA))
		else $error("low group mask not written");
	AST_PUD_WRITE: assert property (IO_WE && IO_ADDR == ADR_MCU_CONTROL
		|=> PULLUP_DISABLE == $past(IO_WDATA[BIT_PULLUP_DIS]))
		else $error("pull-up disable bit not written");
	// Sleep: wake stays asynchronous, level requests wait for the core
	AST_PC_NOCLK: assert property (!io_run && |pc_diff[7:0] && s_q.pc_en[0] |-> WAKE) // [RULE12]
		else $error("pin change lost with I/O clock stopped");
	AST_LEVEL_QUIET: assert property (SLEEP_ACTIVE && !ext_flag[0] |-> !IRQ_REQ[IRQ_EXT_A]) // [RULE18]
		else $error("level request issued before wake-up ended");
	AST_CLK_AWAKE: assert property (!SLEEP_ACTIVE || SLEEP_IDLE |-> IO_CLK_RUN) // [RULE17]
		else $error("I/O clock stopped while awake or idle");
	COV_PC_IRQ: cover property (s_q.pc_en[0] && pc_hit[0] ##1 IRQ_REQ[IRQ_PC_LOW]);
	COV_LOCKED: cover property (lock_mute && GLOBAL_IE);
	COV_WAKE: cover property (SLEEP_ACTIVE && !SLEEP_IDLE && WAKE);
endmodule : ivp_top

//--- test/ivp_core_model.sv
// Core-side model: register port cycles and instruction-end pulses.
// Assumes one-cycle strobes and read data that is registered a cycle after the read strobe.
`timescale 1ns/1ns
module ivp_core_model import ivp_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] io_rdata,
	output logic [7:0] io_addr,
	output logic [7:0] io_wdata,
	output logic io_we,
	output logic io_re,
	output logic instr_done
);
	logic [1:0] ph_q;
	// Strobes idle from time zero so nothing is taken before reset ends
	initial begin
		io_addr = 8'h00;
		io_wdata = 8'h00;
		io_we = 1'b0;
		io_re = 1'b0;
	end
	// Instruction ends every other cycle, so the hold after a select write is short but real
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_q <= 2'h0;
		end else begin
			ph_q <= ph_q + 2'h1;
		end
	end
	assign instr_done = ph_q[0];
	// One write; data is scrambled after the taking edge so a late sample shows up
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		io_addr <= a;
		io_wdata <= d;
		io_we <= 1'b1;
		@(posedge clk);
		io_we <= 1'b0;
		io_wdata <= ~d;
	endtask : wr
	// One read; data is picked up once the registered answer has landed
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		io_addr <= a;
		io_re <= 1'b1;
		@(posedge clk);
		io_re <= 1'b0;
		@(posedge clk);
		#1 d = io_rdata;
	endtask : rd
	// Unlock, then the select write two cycles later, well inside the window
	task automatic move_vectors(input logic sel);
		wr(ADR_MCU_CONTROL, 8'h01);
		wr(ADR_MCU_CONTROL, {6'h00, sel, 1'b0});
	endtask : move_vectors
endmodule : ivp_core_model

//--- test/tb.sv
// Self-checking bench for the vector select and pin interrupt block.
// Assumes the core model for register traffic; pins and sleep levels come from here.
`timescale 1ns/1ns
module tb import ivp_pkg::*; ();
	logic mclk, rst_n, io_we, io_re, instr_done, irq_allow, wake, io_clk_run, pullup_dis;
	logic [7:0] io_addr, io_wdata, io_rdata, rv;
	logic [1:0] ext_pin;
	logic [23:0] pc_pin;
	logic [4:0] irq_ack, irq_req;
	logic sleep_active, sleep_idle, exec_in_boot, app_lock, boot_lock, global_ie;
	logic [12:0] vec_base;
	int err_count, n_compared, cyc, b, g;
	int msk[3];
	ivp_top u_ivp_top (.MCLK(mclk), .RST_N(rst_n), .IO_ADDR(io_addr), .IO_WDATA(io_wdata), .IO_WE(io_we),
		.IO_RE(io_re), .IO_RDATA(io_rdata), .EXT_PIN(ext_pin), .PC_PIN(pc_pin), .IRQ_ACK(irq_ack),
		.INSTR_DONE(instr_done), .GLOBAL_IE(global_ie), .SLEEP_ACTIVE(sleep_active), .SLEEP_IDLE(sleep_idle),
		.EXEC_IN_BOOT(exec_in_boot), .APP_LOCK_PROG(app_lock), .BOOT_LOCK_PROG(boot_lock),
		.BOOT_SIZE_FUSES(2'h0), .VEC_BASE(vec_base), .IRQ_REQ(irq_req), .IRQ_ALLOW(irq_allow),
		.WAKE(wake), .IO_CLK_RUN(io_clk_run), .PULLUP_DISABLE(pullup_dis));
	ivp_core_model u_ivp_core_model (.clk(mclk), .rst_n(rst_n), .io_rdata(io_rdata), .io_addr(io_addr),
		.io_wdata(io_wdata), .io_we(io_we), .io_re(io_re), .instr_done(instr_done));
	// Free-running core clock, 10 ns
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Hang guard: the tests need well under a thousand cycles
	always @(posedge mclk) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			err_count = err_count + 1;
			print_verdict();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			err_count = err_count + 1;
			$display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	// Pin held four cycles, longer than the sample and compare path
	task automatic pin_a(input logic v);
		@(posedge mclk);
		ext_pin[0] <= v;
		repeat (4) @(posedge mclk);
		#1;
	endtask : pin_a
	task automatic pulse_ack(input logic [4:0] v);
		@(posedge mclk);
		irq_ack <= v;
		@(posedge mclk);
		irq_ack <= 5'h00;
		#1;
	endtask : pulse_ack
	task automatic lock_case(input logic al, input logic bl, input logic ib, input logic exp);
		@(posedge mclk);
		app_lock <= al;
		boot_lock <= bl;
		exec_in_boot <= ib;
		#1 chk(irq_allow, exp, "lock mute");
	endtask : lock_case
	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict
	// Main sequence
	initial begin
		err_count = 0;
		n_compared = 0;
		cyc = 0;
		rst_n = 1'b0;
		ext_pin = 2'h3;
		pc_pin = 24'h000000;
		irq_ack = 5'h00;
		{sleep_active, sleep_idle, exec_in_boot, app_lock, boot_lock} = 5'h00;
		global_ie = 1'b1;
		void'($urandom(32'he90b5f72));
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		u_ivp_core_model.rd(ADR_MCU_CONTROL, rv);
		chk(rv, REG_RESET, "control reset");
		chk(vec_base, FLASH_BASE, "base at reset");
		u_ivp_core_model.rd(8'h00, rv);
		chk(rv, 8'h00, "unmapped read");
		$display("reset test done");
		// Open the window, then move vectors to the boot section
		u_ivp_core_model.wr(ADR_MCU_CONTROL, 8'h01);
		#1 chk(irq_allow, 1'b0, "blocked in window");
		u_ivp_core_model.wr(ADR_MCU_CONTROL, 8'h02);
		u_ivp_core_model.rd(ADR_MCU_CONTROL, rv);
		chk(rv, 8'h02, "select set, unlock gone");
		chk(vec_base, 13'h1c00, "boot base");
		chk(irq_allow, 1'b1, "block over, global enable kept");
		@(posedge mclk);
		global_ie <= 1'b0;
		#1 chk(irq_allow, 1'b0, "allow follows global enable");
		@(posedge mclk);
		global_ie <= 1'b1;
		lock_case(1'b1, 1'b0, 1'b0, 1'b0);
		lock_case(1'b1, 1'b0, 1'b1, 1'b1);
		u_ivp_core_model.move_vectors(1'b0);
		u_ivp_core_model.rd(ADR_MCU_CONTROL, rv);
		chk(rv, 8'h00, "select cleared");
		chk(vec_base, FLASH_BASE, "back to flash base");
		lock_case(1'b0, 1'b1, 1'b1, 1'b0);
		lock_case(1'b0, 1'b1, 1'b0, 1'b1);
		// Window left to expire: a late select write must be ignored
		u_ivp_core_model.wr(ADR_MCU_CONTROL, 8'h01);
		repeat (5) @(posedge mclk);
		#1 chk(irq_allow, 1'b1, "block ends after four");
		u_ivp_core_model.wr(ADR_MCU_CONTROL, 8'h02);
		u_ivp_core_model.rd(ADR_MCU_CONTROL, rv);
		chk(rv, 8'h00, "late select ignored");
		u_ivp_core_model.wr(ADR_MCU_CONTROL, 8'h10);
		u_ivp_core_model.rd(ADR_MCU_CONTROL, rv);
		chk({rv, 7'h00, pullup_dis}, 16'h1001, "pull-up disable bit");
		$display("vector test done");
		// Every sense code on pin a: fall, then rise
		u_ivp_core_model.wr(ADR_EXT_MASK, 8'h03);
		for (int c = 3; c >= 0; c--) begin
			u_ivp_core_model.wr(ADR_EXT_SENSE, 8'(c));
			u_ivp_core_model.wr(ADR_EXT_FLAG, 8'h03);
			pin_a(1'b0);
			chk(irq_req[IRQ_EXT_A], c != 3, "request after fall");
			u_ivp_core_model.rd(ADR_EXT_FLAG, rv);
			chk(rv[0], c == 1 || c == 2, "flag after fall");
			chk(irq_req[IRQ_EXT_A], c != 3, "low level still asking");
			u_ivp_core_model.wr(ADR_EXT_FLAG, 8'h01);
			pin_a(1'b1);
			chk(irq_req[IRQ_EXT_A], c == 1 || c == 3, "request after rise");
			pulse_ack(5'h01);
			chk(irq_req[IRQ_EXT_A], 1'b0, "entry clears flag");
		end
		// Both pins now in level mode: pin b must request while held low
		@(posedge mclk);
		ext_pin[1] <= 1'b0;
		#1 chk(irq_req[IRQ_EXT_A + 1], 1'b1, "pin b low level");
		@(posedge mclk);
		ext_pin[1] <= 1'b1;
		$display("sense test done");
		// Random masks, random single toggles
		u_ivp_core_model.wr(ADR_PC_CTRL, 8'h07);
		for (int k = 0; k < 3; k++) begin
			msk[k] = $urandom_range(255);
			u_ivp_core_model.wr(ADR_PC_MASK_LOW + 8'(k), 8'(msk[k]));
		end
		repeat (24) begin
			b = $urandom_range(23);
			b = (b == 15) ? 14 : b;
			g = b / 8;
			@(posedge mclk);
			pc_pin[b] <= ~pc_pin[b];
			repeat (3) @(posedge mclk);
			#1 chk(irq_req[IRQ_PC_LOW + g], (msk[g] >> (b % 8)) & 1, "group request");
			pulse_ack(5'h1c);
			chk(irq_req[4:2], 3'h0, "no request once copy matches");
		end
		$display("pin change test done");
		// Deep sleep: no I/O clock, edges lost, level and pin change still wake
		u_ivp_core_model.wr(ADR_PC_MASK_LOW, 8'hff);
		u_ivp_core_model.wr(ADR_EXT_SENSE, 8'h03);
		@(posedge mclk);
		sleep_active <= 1'b1;
		#1 chk(io_clk_run, 1'b0, "io clock stopped");
		pin_a(1'b0);
		pin_a(1'b1);
		u_ivp_core_model.rd(ADR_EXT_FLAG, rv);
		chk(rv[0], 1'b0, "edge lost in sleep");
		@(posedge mclk);
		pc_pin[0] <= ~pc_pin[0];
		#1 chk(wake, 1'b1, "pin change wake");
		@(posedge mclk);
		pc_pin[0] <= ~pc_pin[0];
		#1 chk(wake, 1'b0, "wake ends with pin restored");
		u_ivp_core_model.wr(ADR_EXT_SENSE, 8'h00);
		pin_a(1'b0);
		chk({wake, irq_req[IRQ_EXT_A]}, 2'h2, "level wakes, request held back");
		@(posedge mclk);
		sleep_active <= 1'b0;
		#1 chk(irq_req[IRQ_EXT_A], 1'b1, "level request after wake");
		@(posedge mclk);
		{sleep_active, sleep_idle} <= 2'h3;
		#1 chk(io_clk_run, 1'b1, "clock runs in idle");
		pin_a(1'b1);
		$display("sleep test done");
		print_verdict();
	end
endmodule : tb
